// >>> hdl/ppfmc_pkg.sv
// Constants and types shared by the power and fiber mode control block
package ppfmc_pkg;
  // Cable fault distance: count width, nominal 0.4 m per count in decimetres
  localparam int DIST_W = 9;
  localparam logic [7:0] DIST_SCALE_DM_RST = 8'h04;
  // Control bit positions within the two control words
  localparam int CTL1F_PSAVE_BIT = 10;
  localparam int CTL0_PDOWN_BIT = 11;
  // Back-to-back strap code
  localparam logic [2:0] CFG_MII_B2B = 3'b110;
  // Far-end fault pattern: ones then one zero
  localparam int FEF_ONES = 84;
  localparam logic [6:0] FEF_LAST = 7'h54;
  // Graded signal-detect input comparator outputs
  localparam logic [1:0] SD_COPPER = 2'b00;
  localparam logic [1:0] SD_FIBER_NOSIG = 2'b01;
  localparam logic [1:0] SD_FIBER_SIG = 2'b11;
  // Reference clock and the frequency of the receive clock in MII mode
  localparam int MCLK_MHZ = 25;
  localparam int RXCLK_MHZ = 25;
  localparam int RXCLK_DIV = MCLK_MHZ / RXCLK_MHZ;
  typedef enum logic [1:0] {PPFMC_COPPER, PPFMC_FIBER_NOSIG,
    PPFMC_FIBER_SIG} ppfmc_media_e;
  typedef enum logic [1:0] {PPFMC_RUN, PPFMC_SAVE, PPFMC_DOWN}
    ppfmc_pwr_e;
endpackage

// >>> hdl/ppfmc_sync2.sv
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ns
module ppfmc_sync2
  import ppfmc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Level in and out
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // ppfmc_sync2

// >>> hdl/ppfmc_fef_gen.sv
// Far-end fault pattern generator: 84 ones then one zero, repeating
`timescale 1ns/1ns
module ppfmc_fef_gen
  import ppfmc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control and serial pattern
  input wire logic run_i,
  output logic bit_o
);
  logic [6:0] cnt_r;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !run_i)
      cnt_r <= 7'h00;
    else if (cnt_r == FEF_LAST)
      cnt_r <= 7'h00;
    else
      cnt_r <= cnt_r + 7'h01;
  end

  // Zero on the last slot of each period and whenever run_i is low
  assign bit_o = run_i && (cnt_r != FEF_LAST);

  a_fef_zero_slot: assert property (@(posedge mclk_i) disable iff (rst_i)
    run_i && cnt_r == FEF_LAST |-> !bit_o)
    else $error("fault pattern zero missing");
endmodule // ppfmc_fef_gen

// >>> hdl/ppfmc_top.sv
// Power, fiber mode and back-to-back control of a 10/100 transceiver
`timescale 1ns/1ns
module ppfmc_top
  import ppfmc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Management control bits
  input wire logic [15:0] ctl0_i,
  input wire logic [15:0] ctl1f_i,
  input wire logic [7:0] dist_scale_i,
  input wire logic dist_scale_we_i,
  // Line status from analog side
  input wire logic an_enable_i,
  input wire logic cable_present_i,
  input wire logic link_up_i,
  input wire logic full_duplex_i,
  input wire logic [DIST_W-1:0] tdr_count_i,
  input wire logic [1:0] sd_level_i,
  // Straps
  input wire logic fault_report_disable_strap_i,
  input wire logic [2:0] cfg_strap_i,
  input wire logic mii_mode_i,
  // Transmit clock from peer in back-to-back mode
  input wire logic transmit_clock_in_i,
  // Block enables
  output logic tx_en_o,
  output logic energy_det_en_o,
  output logic pll_en_o,
  output logic core_en_o,
  output logic mgmt_en_o,
  // Path bypass and mode
  output logic scrambler_bypass_o,
  output logic encoder_bypass_o,
  output logic an_bypass_o,
  output logic mdix_auto_en_o,
  output logic speed100_o,
  output logic duplex_full_o,
  output logic fiber_mode_o,
  output logic fiber_signal_o,
  output logic allow_10m_o,
  output logic b2b_mode_o,
  // Fault and pattern
  output logic far_end_fault_o,
  output logic fef_pattern_o,
  output logic fef_active_o,
  // Receive clock and diagnostics
  output logic receive_clock_out_o,
  output logic receive_clock_en_o,
  output logic [DIST_W-1:0] fault_dist_o,
  output logic [7:0] dist_scale_o,
  output logic [15:0] fault_dist_dm_o,
  output logic txc_edge_o
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic sd_lo_s;
  logic sd_hi_s;
  logic cable_s;
  logic txc_s;
  logic txc_d_r;
  // Strap results, declared early since the edge finder reads them
  logic b2b_r;

  ppfmc_sync2 u_sync_sd0 (.mclk_i(mclk_i), .rst_i(rst_i),
    .d_i(sd_level_i[0]), .q_o(sd_lo_s));
  ppfmc_sync2 u_sync_sd1 (.mclk_i(mclk_i), .rst_i(rst_i),
    .d_i(sd_level_i[1]), .q_o(sd_hi_s));
  ppfmc_sync2 u_sync_cab (.mclk_i(mclk_i), .rst_i(rst_i),
    .d_i(cable_present_i), .q_o(cable_s));
  ppfmc_sync2 u_sync_txc (.mclk_i(mclk_i), .rst_i(rst_i),
    .d_i(transmit_clock_in_i), .q_o(txc_s));

  // Peer clock edge finder, only meaningful in back-to-back mode
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      txc_d_r <= 1'b0;
      txc_edge_o <= 1'b0;
    end
    else
    begin
      txc_d_r <= txc_s;
      txc_edge_o <= b2b_r && txc_s && !txc_d_r;
    end
  end

  // ----------------------------------------------------------------
  // Straps, caught one cycle after reset release
  // ----------------------------------------------------------------
  logic strap_take_r;
  logic fef_en_r;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      strap_take_r <= 1'b1;
      fef_en_r <= 1'b1;
      b2b_r <= 1'b0;
    end
    else if (strap_take_r)
    begin
      strap_take_r <= 1'b0;
      fef_en_r <= fault_report_disable_strap_i;
      b2b_r <= (cfg_strap_i == CFG_MII_B2B);
    end
  end

  // ----------------------------------------------------------------
  // Media classification
  // ----------------------------------------------------------------
  ppfmc_media_e media_nxt;
  ppfmc_media_e media_r;

  always_comb
  begin
    // Odd code 10 treated as no signal, the safe side
    if ({sd_hi_s, sd_lo_s} == SD_COPPER)
      media_nxt = PPFMC_COPPER;
    else if ({sd_hi_s, sd_lo_s} == SD_FIBER_SIG)
      media_nxt = PPFMC_FIBER_SIG;
    else
      media_nxt = PPFMC_FIBER_NOSIG;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      media_r <= PPFMC_COPPER;
    else
      media_r <= media_nxt;
  end

  logic fiber_w;
  logic fef_w;
  assign fiber_w = (media_r != PPFMC_COPPER);
  assign fef_w = fiber_w && (media_r == PPFMC_FIBER_NOSIG) && fef_en_r;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  ppfmc_pwr_e pwr_r;
  ppfmc_pwr_e pwr_nxt;
  logic save_ok_w;
  assign save_ok_w = an_enable_i && !cable_s && ctl1f_i[CTL1F_PSAVE_BIT];

  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PPFMC_RUN:
        if (ctl0_i[CTL0_PDOWN_BIT])
          pwr_nxt = PPFMC_DOWN;
        else if (save_ok_w)
          pwr_nxt = PPFMC_SAVE;
      PPFMC_SAVE:
        if (ctl0_i[CTL0_PDOWN_BIT])
          pwr_nxt = PPFMC_DOWN;
        else if (!save_ok_w)
          pwr_nxt = PPFMC_RUN;
      PPFMC_DOWN:
        if (!ctl0_i[CTL0_PDOWN_BIT])
          pwr_nxt = PPFMC_RUN;
      default:
        pwr_nxt = PPFMC_RUN;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      pwr_r <= PPFMC_RUN;
    else
      pwr_r <= pwr_nxt;
  end

  // ----------------------------------------------------------------
  // Block enables and mode outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      tx_en_o <= 1'b1;
      energy_det_en_o <= 1'b1;
      pll_en_o <= 1'b1;
      core_en_o <= 1'b1;
      mgmt_en_o <= 1'b1;
    end
    else
    begin
      tx_en_o <= (pwr_nxt != PPFMC_DOWN);
      energy_det_en_o <= (pwr_nxt != PPFMC_DOWN);
      pll_en_o <= (pwr_nxt != PPFMC_DOWN);
      core_en_o <= (pwr_nxt == PPFMC_RUN);
      mgmt_en_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      scrambler_bypass_o <= 1'b0;
      encoder_bypass_o <= 1'b0;
      an_bypass_o <= 1'b0;
      mdix_auto_en_o <= 1'b1;
      speed100_o <= 1'b0;
      duplex_full_o <= 1'b1;
      fiber_mode_o <= 1'b0;
      fiber_signal_o <= 1'b0;
      allow_10m_o <= 1'b1;
      b2b_mode_o <= 1'b0;
      far_end_fault_o <= 1'b0;
    end
    else
    begin
      scrambler_bypass_o <= fiber_w;
      encoder_bypass_o <= fiber_w;
      an_bypass_o <= fiber_w;
      mdix_auto_en_o <= !fiber_w;
      speed100_o <= fiber_w || b2b_r;
      duplex_full_o <= full_duplex_i;
      fiber_mode_o <= fiber_w;
      fiber_signal_o <= (media_r == PPFMC_FIBER_SIG);
      allow_10m_o <= !b2b_r && !fiber_w;
      b2b_mode_o <= b2b_r;
      far_end_fault_o <= fef_w;
    end
  end

  // ----------------------------------------------------------------
  // Far-end fault pattern
  // ----------------------------------------------------------------
  logic fef_bit_w;
  logic fef_run_w;
  // Pattern is stopped in power-down since the transmitter is off
  assign fef_run_w = fef_w && (pwr_r != PPFMC_DOWN);

  ppfmc_fef_gen u_fef (.mclk_i(mclk_i), .rst_i(rst_i),
    .run_i(fef_run_w), .bit_o(fef_bit_w));

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      fef_pattern_o <= 1'b0;
      fef_active_o <= 1'b0;
    end
    else
    begin
      fef_pattern_o <= fef_bit_w;
      fef_active_o <= fef_run_w;
    end
  end

  // ----------------------------------------------------------------
  // Receive clock gating
  // ----------------------------------------------------------------
  logic rxc_gate_r;
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rxc_gate_r <= 1'b1;
    else if (pwr_nxt == PPFMC_DOWN)
      rxc_gate_r <= 1'b0;
    else if (mii_mode_i && pwr_nxt == PPFMC_SAVE)
      rxc_gate_r <= 1'b0;
    else if (!rxc_gate_r && cable_s && link_up_i)
      rxc_gate_r <= 1'b1;
    else if (!mii_mode_i && pwr_nxt == PPFMC_RUN)
      rxc_gate_r <= 1'b1;
  end

  // Toggles each cycle while enabled; a gated clock stops low
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      receive_clock_out_o <= 1'b0;
      receive_clock_en_o <= 1'b1;
    end
    else
    begin
      receive_clock_out_o <= rxc_gate_r && !receive_clock_out_o;
      receive_clock_en_o <= rxc_gate_r;
    end
  end

  // ----------------------------------------------------------------
  // Cable fault distance
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      fault_dist_o <= '0;
      dist_scale_o <= DIST_SCALE_DM_RST;
      fault_dist_dm_o <= 16'h0000;
    end
    else
    begin
      fault_dist_o <= tdr_count_i;
      if (dist_scale_we_i)
        dist_scale_o <= dist_scale_i;
      fault_dist_dm_o <= 16'(tdr_count_i) * 16'(dist_scale_o);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_save_req;
    an_enable_i && !cable_s && ctl1f_i[CTL1F_PSAVE_BIT]
      && !ctl0_i[CTL0_PDOWN_BIT];
  endsequence

  a_save_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
    pwr_r == PPFMC_RUN ##0 s_save_req |=> pwr_r == PPFMC_SAVE)
    else $error("power saving not entered");
  a_save_exit: assert property (@(posedge mclk_i) disable iff (rst_i)
    !ctl1f_i[CTL1F_PSAVE_BIT] |=> pwr_r != PPFMC_SAVE)
    else $error("power saving held after clear");
  a_save_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
    pwr_r == PPFMC_SAVE |-> tx_en_o && energy_det_en_o && pll_en_o
      && !core_en_o)
    else $error("wrong blocks in power saving");
  a_pdown_entry: assert property (@(posedge mclk_i) disable iff (rst_i)
    ctl0_i[CTL0_PDOWN_BIT] |=> !core_en_o && !tx_en_o)
    else $error("power down not entered");
  a_mgmt_alive: assert property (@(posedge mclk_i) disable iff (rst_i)
    pwr_r == PPFMC_DOWN |-> mgmt_en_o)
    else $error("management off in power down");
  a_fiber_bypass: assert property (@(posedge mclk_i) disable iff (rst_i)
    fiber_w |=> scrambler_bypass_o && encoder_bypass_o
      && an_bypass_o && !mdix_auto_en_o && speed100_o)
    else $error("fiber bypass missing");
  a_fef_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
    media_r == PPFMC_FIBER_NOSIG && fef_en_r && !strap_take_r
      |=> far_end_fault_o)
    else $error("far-end fault not flagged");
  a_media_class: assert property (@(posedge mclk_i) disable iff (rst_i)
    {sd_hi_s, sd_lo_s} == SD_COPPER |=> media_r == PPFMC_COPPER)
    else $error("copper not classified");
  a_b2b_no10: assert property (@(posedge mclk_i) disable iff (rst_i)
    b2b_r |=> !allow_10m_o)
    else $error("10M allowed in back-to-back");
  a_rxc_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
    mii_mode_i && pwr_nxt == PPFMC_SAVE |=> ##1 !receive_clock_en_o)
    else $error("receive clock runs in saving");
endmodule // ppfmc_top

// >>> dv/ppfmc_fiber_model.sv
// Behavioural fiber transceiver and back-to-back peer
`timescale 1ns/1ns
module ppfmc_fiber_model
  import ppfmc_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Commands from the bench
  input wire logic fiber_i,
  input wire logic signal_i,
  input wire logic clk_run_i,
  // Device side
  input wire logic rx_bit_i,
  output logic [1:0] sd_level_o,
  output logic peer_clk_o,
  output logic [7:0] run_len_o
);
  logic [7:0] cnt_r = 8'h00;
  // Graded detect; the forced-fiber tie shows as the high level
  assign sd_level_o = !fiber_i ? SD_COPPER :
    (signal_i ? SD_FIBER_SIG : SD_FIBER_NOSIG);
  // Peer receive clock, 320 ns period, still outside traffic
  initial
  begin
    peer_clk_o = 1'b0;
    #7;
    forever
    begin
      #160;
      if (clk_run_i)
        peer_clk_o = !peer_clk_o;
    end
  end
  // Length of each run of ones seen on the line
  always_ff @(posedge mclk_i)
  begin
    if (rx_bit_i)
      cnt_r <= cnt_r + {7'h00, cnt_r != 8'hff};
    else
    begin
      run_len_o <= cnt_r;
      cnt_r <= 8'h00;
    end
  end
endmodule // ppfmc_fiber_model

// >>> dv/ppfmc_top_test.sv
// Self-checking testbench of the power and fiber mode control block
`timescale 1ns/1ns
module ppfmc_top_test;
  import ppfmc_pkg::*;
  logic mclk_i, rst_i, dist_scale_we_i, an_enable_i, cable_present_i;
  logic link_up_i, full_duplex_i, fault_report_disable_strap_i;
  logic mii_mode_i, transmit_clock_in_i, fiber, signal, clk_run;
  logic [15:0] ctl0_i, ctl1f_i, fault_dist_dm_o;
  logic [7:0] dist_scale_i, dist_scale_o, run_len;
  logic [DIST_W-1:0] tdr_count_i, fault_dist_o;
  logic [1:0] sd_level_i;
  logic [2:0] cfg_strap_i;
  logic tx_en_o, energy_det_en_o, pll_en_o, core_en_o, mgmt_en_o;
  logic scrambler_bypass_o, encoder_bypass_o, an_bypass_o, mdix_auto_en_o;
  logic speed100_o, duplex_full_o, fiber_mode_o, fiber_signal_o;
  logic allow_10m_o, b2b_mode_o, far_end_fault_o, fef_pattern_o;
  logic fef_active_o, receive_clock_out_o, receive_clock_en_o, txc_edge_o;
  int num_errors = 0;
  int checks = 0;
  int seed = 32'hd238;
  int n;
  logic sv;
  ppfmc_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .ctl0_i(ctl0_i),
    .ctl1f_i(ctl1f_i), .dist_scale_i(dist_scale_i),
    .dist_scale_we_i(dist_scale_we_i), .an_enable_i(an_enable_i),
    .cable_present_i(cable_present_i), .link_up_i(link_up_i),
    .full_duplex_i(full_duplex_i), .tdr_count_i(tdr_count_i),
    .sd_level_i(sd_level_i), .cfg_strap_i(cfg_strap_i),
    .fault_report_disable_strap_i(fault_report_disable_strap_i),
    .mii_mode_i(mii_mode_i), .transmit_clock_in_i(transmit_clock_in_i),
    .tx_en_o(tx_en_o), .energy_det_en_o(energy_det_en_o),
    .pll_en_o(pll_en_o), .core_en_o(core_en_o), .mgmt_en_o(mgmt_en_o),
    .scrambler_bypass_o(scrambler_bypass_o),
    .encoder_bypass_o(encoder_bypass_o), .an_bypass_o(an_bypass_o),
    .mdix_auto_en_o(mdix_auto_en_o), .speed100_o(speed100_o),
    .duplex_full_o(duplex_full_o), .fiber_mode_o(fiber_mode_o),
    .fiber_signal_o(fiber_signal_o), .allow_10m_o(allow_10m_o),
    .b2b_mode_o(b2b_mode_o), .far_end_fault_o(far_end_fault_o),
    .fef_pattern_o(fef_pattern_o), .fef_active_o(fef_active_o),
    .receive_clock_out_o(receive_clock_out_o),
    .receive_clock_en_o(receive_clock_en_o), .fault_dist_o(fault_dist_o),
    .dist_scale_o(dist_scale_o), .fault_dist_dm_o(fault_dist_dm_o),
    .txc_edge_o(txc_edge_o));
  ppfmc_fiber_model partner (.mclk_i(mclk_i), .fiber_i(fiber),
    .signal_i(signal), .clk_run_i(clk_run), .rx_bit_i(fef_pattern_o),
    .sd_level_o(sd_level_i), .peer_clk_o(transmit_clock_in_i),
    .run_len_o(run_len));
  // ----------------------------------------------------------------
  // Clock, helpers and expectations
  // ----------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever
      #20 mclk_i = !mclk_i;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Straps are held steady through and after reset
  task automatic do_reset(input logic strap, input logic [2:0] cfg);
    rst_i = 1'b1;
    fault_report_disable_strap_i = strap;
    cfg_strap_i = cfg;
    tick(8);
    rst_i = 1'b0;
    tick(3);
  endtask
  function automatic logic save_exp(input logic an, cab, bit10);
    return an && !cab && bit10;
  endfunction
  function automatic logic fault_exp(input logic fib, sig, strap);
    return fib && !sig && strap;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #(40 * 5000);
    num_errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {ctl0_i, ctl1f_i, dist_scale_i, dist_scale_we_i, tdr_count_i} = '0;
    {an_enable_i, cable_present_i, link_up_i, full_duplex_i} = 4'hf;
    {mii_mode_i, fiber, signal, clk_run} = 4'h8;
    do_reset(1'b1, 3'b111);
    chk_val(16'(dist_scale_o), 16'(DIST_SCALE_DM_RST));
    chk_bit(b2b_mode_o, 1'b0);
    chk_bit(allow_10m_o, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      tdr_count_i = (i == 0) ? 9'h1ff : 9'($random(seed));
      dist_scale_i = (i == 0) ? 8'h80 : {1'b0, 7'($random(seed))};
      dist_scale_we_i = 1'b1;
      tick(1);
      dist_scale_we_i = 1'b0;
      tick(3);
      chk_val(16'(fault_dist_o), 16'(tdr_count_i));
      chk_val(fault_dist_dm_o, 16'(tdr_count_i) * 16'(dist_scale_i));
    end
    $display("test distance done");
    for (int i = 0; i < 24; i++)
    begin
      {an_enable_i, cable_present_i, ctl1f_i[10]} = 3'($random(seed));
      link_up_i = cable_present_i;
      tick(5);
      sv = save_exp(an_enable_i, cable_present_i, ctl1f_i[10]);
      chk_bit(core_en_o, !sv);
      chk_bit(tx_en_o & energy_det_en_o & pll_en_o, 1'b1);
      if (sv)
        chk_bit(receive_clock_en_o, 1'b0);
    end
    {an_enable_i, cable_present_i, link_up_i, ctl1f_i[10]} = 4'h9;
    tick(5);
    cable_present_i = 1'b1;
    tick(5);
    chk_bit(receive_clock_en_o, 1'b0);
    link_up_i = 1'b1;
    tick(5);
    chk_bit(receive_clock_en_o, 1'b1);
    sv = receive_clock_out_o;
    tick(1);
    chk_bit(receive_clock_out_o, !sv);
    {cable_present_i, link_up_i} = 2'b00;
    ctl0_i[11] = 1'b1;
    tick(3);
    chk_bit(core_en_o | tx_en_o | energy_det_en_o | pll_en_o, 1'b0);
    chk_bit(mgmt_en_o, 1'b1);
    ctl0_i[11] = 1'b0;
    ctl1f_i[10] = 1'b0;
    tick(3);
    chk_bit(core_en_o, 1'b1);
    $display("test power done");
    for (int c = 0; c < 3; c++)
    begin
      fiber = (c != 0);
      signal = (c == 2);
      full_duplex_i = 1'($random(seed));
      tick(6);
      chk_bit(fiber_mode_o, fiber);
      chk_bit(scrambler_bypass_o & encoder_bypass_o, fiber);
      chk_bit(an_bypass_o, fiber);
      chk_bit(mdix_auto_en_o, !fiber);
      chk_bit(fiber_signal_o, fiber & signal);
      chk_bit(far_end_fault_o, fault_exp(fiber, signal, 1'b1));
      if (fiber)
      begin
        chk_bit(speed100_o, 1'b1);
        chk_bit(duplex_full_o, full_duplex_i);
      end
      if (c == 1)
      begin
        chk_bit(fef_active_o, 1'b1);
        tick(200);
        chk_val(16'(run_len), 16'(FEF_ONES));
      end
    end
    $display("test fiber done");
    do_reset(1'b0, CFG_MII_B2B);
    {fiber, signal} = 2'b10;
    tick(8);
    chk_bit(far_end_fault_o, 1'b0);
    chk_bit(fiber_mode_o, 1'b1);
    chk_bit(b2b_mode_o, 1'b1);
    chk_bit(allow_10m_o, 1'b0);
    clk_run = 1'b1;
    n = 0;
    repeat (160)
    begin
      tick(1);
      n += int'(txc_edge_o === 1'b1);
    end
    clk_run = 1'b0;
    chk_bit(n >= 19 && n <= 21, 1'b1);
    $display("test back-to-back done");
    print_verdict();
  end
endmodule // ppfmc_top_test
